/* hdl/pwm_pkg.sv */
package pwm_pkg;

  // Bus and counter widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int FRAC_W = 5;
  localparam int SEL_W = 2;
  localparam int RATE_W = 4;
  localparam int SAFE_W = 2;
  localparam int NUM_EDGES = 4;

  // Register word addresses
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_START = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h2;
  localparam logic [ADDR_W-1:0] REG_EDGE_BASE = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PFRAC = 4'h7;
  localparam logic [ADDR_W-1:0] REG_EFRAC_BASE = 4'h8;
  localparam logic [ADDR_W-1:0] REG_FRAC_CTRL = 4'hC;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'hD;
  localparam logic [ADDR_W-1:0] REG_COUNT = 4'hE;

  // Control field positions
  localparam int CTL_SEL_LSB = 0;
  localparam int CTL_FORCE_INIT = 2;
  localparam int CTL_RATE_LSB = 4;
  localparam int CTL_AUTO_CLR = 8;
  localparam int CTL_SAFE_A_LSB = 9;
  localparam int CTL_SAFE_B_LSB = 11;

  // Fraction control and status bits
  localparam int FRAC_EN_BIT = 0;
  localparam int ST_FAULT = 0;
  localparam int ST_PHIT = 1;
  localparam int ST_CLR_REQ = 2;

  // Reset values
  localparam logic [DATA_W-1:0] CONTROL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] START_RST = 16'h0000;
  localparam logic [DATA_W-1:0] PERIOD_RST = 16'hFFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  typedef enum logic [1:0] {
    INIT_LOCAL = 2'b00,
    INIT_MRELOAD = 2'b01,
    INIT_MSYNC = 2'b10,
    INIT_EXT = 2'b11
  } init_sel_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic a;
    logic a_oe;
    logic b;
    logic b_oe;
  } pins_s;

endpackage : pwm_pkg

/* hdl/pwm_submodule.sv */
module pwm_submodule #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire pwm_pkg::bus_req_s bus,
  output logic [pwm_pkg::DATA_W-1:0] rdata,
  input wire logic master_sync_in,
  input wire logic master_reload_in,
  input wire logic external_sync_input,
  input wire logic force_in,
  input wire logic fault_in,
  output logic local_sync_out,
  output logic master_reload_out,
  output pwm_pkg::pins_s pins,
  output logic [pwm_pkg::FRAC_W-1:0] fine_a,
  output logic [pwm_pkg::FRAC_W-1:0] fine_b
);
  import pwm_pkg::*;

  if (CNT_W != DATA_W) begin : g_width_check
    $error("CNT_W must equal the register width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [DATA_W-1:0] control;
  logic [CNT_W-1:0] start_value;
  logic [CNT_W-1:0] period_compare;
  logic [CNT_W-1:0] edge_cmp [NUM_EDGES];
  logic [DATA_W-1:0] period_fraction;
  logic [DATA_W-1:0] edge_fraction [NUM_EDGES];
  logic frac_en;
  logic [CNT_W-1:0] count;
  logic [DATA_W-1:0] acc;
  logic stretch;
  logic phit;
  logic fault_latch;
  logic clr_req;
  logic [RATE_W-1:0] reload_cnt;
  logic raw_a;
  logic raw_b;

  init_sel_e sel;
  logic force_init_enable;
  logic auto_clr;
  logic src_evt;
  logic init_evt;
  logic local_hit;
  logic [DATA_W:0] acc_sum;
  logic [FRAC_W:0] dly [NUM_EDGES];
  logic [NUM_EDGES-1:0] edge_hit;
  logic status_wr;

  // Counter equals compare plus a carry of one clock
  function automatic logic hit(input logic [CNT_W-1:0] cnt,
                               input logic [CNT_W-1:0] cmp,
                               input logic carry);
    return {1'b0, cnt} == ({1'b0, cmp} + {{CNT_W{1'b0}}, carry});
  endfunction : hit

  // Edge fraction plus accumulated period fraction, top bits only
  function automatic logic [FRAC_W:0] edge_delay(
    input logic [DATA_W-1:0] frac,
    input logic [DATA_W-1:0] acc_in,
    input logic en);
    if (!en) begin
      return '0;
    end
    return {1'b0, frac[DATA_W-1 -: FRAC_W]} +
           {1'b0, acc_in[DATA_W-1 -: FRAC_W]};
  endfunction : edge_delay

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  // Init source selection and force event
  always_comb begin
    sel = init_sel_e'(control[CTL_SEL_LSB +: SEL_W]);
    force_init_enable = control[CTL_FORCE_INIT];
    auto_clr = control[CTL_AUTO_CLR];
    local_hit = hit(count, period_compare, stretch);
    unique case (sel)
      INIT_LOCAL: src_evt = local_hit;
      INIT_MRELOAD: src_evt = master_reload_in;
      INIT_MSYNC: src_evt = master_sync_in;
      INIT_EXT: src_evt = external_sync_input;
    endcase
    init_evt = src_evt | (force_init_enable & force_in);
    acc_sum = {1'b0, acc} + {1'b0, period_fraction};
    status_wr = bus.wr && (bus.addr == REG_STATUS);
  end

  // Edge delays and matches
  always_comb begin
    for (int i = 0; i < NUM_EDGES; i++) begin
      dly[i] = edge_delay(edge_fraction[i], acc, frac_en);
      edge_hit[i] = hit(count, edge_cmp[i], dly[i][FRAC_W]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  // Software writes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      control <= CONTROL_RST;
      start_value <= START_RST;
      period_compare <= PERIOD_RST;
      period_fraction <= ZERO_WORD;
      frac_en <= 1'b0;
      for (int i = 0; i < NUM_EDGES; i++) begin
        edge_cmp[i] <= ZERO_WORD;
        edge_fraction[i] <= ZERO_WORD;
      end
    end else if (bus.wr) begin
      for (int i = 0; i < NUM_EDGES; i++) begin
        if (bus.addr == REG_EDGE_BASE + ADDR_W'(i)) begin
          edge_cmp[i] <= bus.wdata;
        end
        if (bus.addr == REG_EFRAC_BASE + ADDR_W'(i)) begin
          edge_fraction[i] <= bus.wdata;
        end
      end
      if (bus.addr == REG_CONTROL) begin
        control <= bus.wdata;
      end
      if (bus.addr == REG_START) begin
        start_value <= bus.wdata;
      end
      if (bus.addr == REG_PERIOD) begin
        period_compare <= bus.wdata;
      end
      if (bus.addr == REG_PFRAC) begin
        period_fraction <= bus.wdata;
      end
      if (bus.addr == REG_FRAC_CTRL) begin
        frac_en <= bus.wdata[FRAC_EN_BIT];
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= ZERO_WORD;
    end else begin
      rdata <= ZERO_WORD;
      if (bus.rd) begin
        for (int i = 0; i < NUM_EDGES; i++) begin
          if (bus.addr == REG_EDGE_BASE + ADDR_W'(i)) begin
            rdata <= edge_cmp[i];
          end
          if (bus.addr == REG_EFRAC_BASE + ADDR_W'(i)) begin
            rdata <= edge_fraction[i];
          end
        end
        if (bus.addr == REG_CONTROL) begin
          rdata <= control;
        end
        if (bus.addr == REG_START) begin
          rdata <= start_value;
        end
        if (bus.addr == REG_PERIOD) begin
          rdata <= period_compare;
        end
        if (bus.addr == REG_PFRAC) begin
          rdata <= period_fraction;
        end
        if (bus.addr == REG_FRAC_CTRL) begin
          rdata[FRAC_EN_BIT] <= frac_en;
        end
        if (bus.addr == REG_STATUS) begin
          rdata[ST_FAULT] <= fault_latch;
          rdata[ST_PHIT] <= phit;
          rdata[ST_CLR_REQ] <= clr_req;
        end
        if (bus.addr == REG_COUNT) begin
          rdata <= count;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base

  // Counter load or count up
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= START_RST;
    end else if (init_evt) begin
      count <= start_value;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

  // Period fraction accumulator, carry stretches next period
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= ZERO_WORD;
      stretch <= 1'b0;
    end else if (!frac_en) begin
      acc <= ZERO_WORD;
      stretch <= 1'b0;
    end else if (local_hit) begin
      acc <= acc_sum[DATA_W-1:0];
      stretch <= acc_sum[DATA_W];
    end
  end

  // Period compare hit flag, set wins over write-one clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phit <= 1'b0;
    end else if (local_hit) begin
      phit <= 1'b1;
    end else if (status_wr && bus.wdata[ST_PHIT]) begin
      phit <= 1'b0;
    end
  end

  // Local sync and master reload pulses for followers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      local_sync_out <= 1'b0;
      master_reload_out <= 1'b0;
      reload_cnt <= '0;
    end else begin
      local_sync_out <= local_hit;
      master_reload_out <= 1'b0;
      if (local_hit) begin
        if (reload_cnt == control[CTL_RATE_LSB +: RATE_W]) begin
          reload_cnt <= '0;
          master_reload_out <= 1'b1;
        end else begin
          reload_cnt <= reload_cnt + RATE_W'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge generation and pins

  // Raw outputs and their fine delay codes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      raw_a <= 1'b0;
      raw_b <= 1'b0;
      fine_a <= '0;
      fine_b <= '0;
    end else begin
      if (edge_hit[1]) begin
        raw_a <= 1'b0;
        fine_a <= dly[1][FRAC_W-1:0];
      end else if (edge_hit[0]) begin
        raw_a <= 1'b1;
        fine_a <= dly[0][FRAC_W-1:0];
      end
      if (edge_hit[3]) begin
        raw_b <= 1'b0;
        fine_b <= dly[3][FRAC_W-1:0];
      end else if (edge_hit[2]) begin
        raw_b <= 1'b1;
        fine_b <= dly[2][FRAC_W-1:0];
      end
    end
  end

  // Fault latch, cleared only at a full cycle start
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fault_latch <= 1'b0;
      clr_req <= 1'b0;
    end else begin
      if (fault_in) begin
        fault_latch <= 1'b1;
      end else if (init_evt && (auto_clr || clr_req)) begin
        fault_latch <= 1'b0;
      end
      if (status_wr && bus.wdata[ST_CLR_REQ]) begin
        clr_req <= 1'b1;
      end else if (!fault_latch) begin
        clr_req <= 1'b0;
      end
    end
  end

  // Pin drive with safe state under fault
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pins <= '0;
    end else if (fault_latch) begin
      pins.a <= control[CTL_SAFE_A_LSB];
      pins.a_oe <= ~control[CTL_SAFE_A_LSB + 1];
      pins.b <= control[CTL_SAFE_B_LSB];
      pins.b_oe <= ~control[CTL_SAFE_B_LSB + 1];
    end else begin
      pins <= '{a: raw_a, a_oe: 1'b1, b: raw_b, b_oe: 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_load;
    ##1 (count == $past(start_value));
  endsequence

  a_init_load: assert property (init_evt |-> s_load)
    else $error("counter missed start value load");
  a_local_wrap: assert property (
    (sel == INIT_LOCAL) && local_hit |-> init_evt)
    else $error("local period end did not reload");
  a_msync_lock: assert property (
    (sel == INIT_MSYNC) && master_sync_in |-> s_load)
    else $error("master sync did not reload");
  a_cmp_free: assert property (
    (sel != INIT_LOCAL) && local_hit && !init_evt
    |=> count == $past(count) + CNT_W'(1))
    else $error("period compare reloaded a follower");
  a_reload_rate: assert property (
    local_hit && reload_cnt == control[CTL_RATE_LSB +: RATE_W]
    |=> master_reload_out ##1 !master_reload_out)
    else $error("master reload pulse wrong");
  a_external_sync_input: assert property (
    (sel == INIT_EXT) && external_sync_input |-> s_load)
    else $error("external sync did not reload");
  a_force_init: assert property (
    force_in && force_init_enable |-> s_load)
    else $error("force event did not reload");
  a_acc_step: assert property (
    frac_en && local_hit |=> {stretch, acc} == $past(acc_sum))
    else $error("period fraction not accumulated");
  a_acc_clear: assert property (!frac_en |=> acc == '0 && !stretch)
    else $error("accumulator not cleared");
  a_edge_fine: assert property (
    edge_hit[0] && !edge_hit[1] && frac_en
    |=> raw_a && fine_a == $past(edge_fraction[0][DATA_W-1 -: FRAC_W])
        + $past(acc[DATA_W-1 -: FRAC_W]))
    else $error("turn-on fine delay wrong");
  a_fault_safe: assert property (
    fault_latch |=> pins.a_oe == ~$past(control[CTL_SAFE_A_LSB + 1]))
    else $error("fault safe state not applied");
  a_full_cycle: assert property (
    $fell(fault_latch) |-> $past(init_evt) && !$past(fault_in))
    else $error("fault cleared away from cycle start");

endmodule : pwm_submodule

/* verification/pwm_stage_model.sv */
////////////////////////////////////////////////////////////////////////
// Gate drivers and current comparators at the far side
module pwm_stage_model (
  input wire pwm_pkg::pins_s pins,
  input wire logic trip,
  input wire logic below,
  output logic fault_level,
  output logic sync_pulse,
  output logic gate_a,
  output logic gate_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // Peak comparator feeds the fault input
  assign fault_level = trip;
  // Valley comparator restarts the counter
  assign sync_pulse = below;
  // Released gates fall to the pull-down level
  assign gate_a = pins.a_oe ? pins.a : 1'b0;
  assign gate_b = pins.b_oe ? pins.b : 1'b0;
endmodule : pwm_stage_model

/* verification/tb_top.sv */
////////////////////////////////////////////////////////////////////////
// Register-level bench for one submodule
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_pkg::*;

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  bus_req_s bus = '0;
  logic [DATA_W-1:0] rdata;
  logic msync = 1'b0;
  logic mreload = 1'b0;
  logic force_ev = 1'b0;
  logic trip = 1'b0;
  logic below = 1'b0;
  logic fault_level, sync_pulse, gate_a, gate_b;
  logic local_sync_out, master_reload_out;
  pins_s pins;
  logic [FRAC_W-1:0] fine_a;
  logic [FRAC_W-1:0] fine_b;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  init_sel_e srcs [3] = '{INIT_EXT, INIT_MSYNC, INIT_MRELOAD};

  // Free-running system clock
  always #2 clk_sys = ~clk_sys;

  pwm_submodule DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .master_sync_in(msync), .master_reload_in(mreload),
    .external_sync_input(sync_pulse), .force_in(force_ev),
    .fault_in(fault_level), .local_sync_out(local_sync_out),
    .master_reload_out(master_reload_out), .pins(pins),
    .fine_a(fine_a), .fine_b(fine_b)
  );

  pwm_stage_model stage (
    .pins(pins), .trip(trip), .below(below), .fault_level(fault_level),
    .sync_pulse(sync_pulse), .gate_a(gate_a), .gate_b(gate_b)
  );

  // Verdict and end of run
  task automatic test_done();
    $display("compares=%0d errors=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      $display("CHECK FAILED t=%0t timeout", $time);
      test_done();
    end
  end

  // Compare and count
  task automatic check(input logic [15:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // One write cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask : wr

  // One read cycle, data taken in the following cycle
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp,
                     input string what);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 check(rdata, exp, what);
  endtask : rdc

  // Pulse one init source, then read the count it produced
  task automatic pulse_count(input int k, output logic [15:0] d);
    @(posedge clk_sys);
    case (k)
      0: below <= 1'b1;
      1: msync <= 1'b1;
      2: mreload <= 1'b1;
      default: force_ev <= 1'b1;
    endcase
    @(posedge clk_sys);
    {below, msync, mreload, force_ev} <= 4'h0;
    bus <= '{addr: REG_COUNT, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : pulse_count

  // Cycles spanned by k periods of sync or reload pulses
  task automatic spans(input bit rl, input int k, output int n);
    int seen;
    seen = 0;
    n = 0;
    while (seen <= k) begin
      @(posedge clk_sys);
      #1;
      if (seen > 0)
        n++;
      if ((rl ? master_reload_out : local_sync_out) === 1'b1)
        seen++;
    end
  endtask : spans

  // Width of the next high pulse on gate A
  task automatic high(output int w);
    w = 0;
    do begin
      @(posedge clk_sys);
      #1;
    end while (gate_a !== 1'b1);
    while (gate_a === 1'b1) begin
      w++;
      @(posedge clk_sys);
      #1;
    end
  endtask : high

  // Main sequence
  initial begin
    logic [15:0] d;
    int n;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc(REG_PERIOD, PERIOD_RST, "period reset");
    rdc(REG_START, START_RST, "start reset");
    rdc(REG_CONTROL, CONTROL_RST, "control reset");
    rdc(4'hF, ZERO_WORD, "unmapped read");
    wr(REG_START, 16'h4000);
    pulse_count(0, d);
    check({15'h0, d == 16'h4000}, 16'h0, "ext ignored");
    // Each pulsed source (external, master sync, master reload) loads the start value
    for (int k = 0; k < 3; k++) begin
      wr(REG_CONTROL, {14'h0, srcs[k]});
      pulse_count(k, d);
      check(d, 16'h4000, "source init");
    end
    wr(REG_CONTROL, 16'h0000);
    pulse_count(3, d);
    check({15'h0, d == 16'h4000}, 16'h0, "force off");
    wr(REG_CONTROL, 16'h0004);
    wr(REG_START, 16'h0000);
    wr(REG_PERIOD, 16'h0003);
    pulse_count(3, d);
    check(d, 16'h0000, "force init");
    spans(0, 1, n);
    check(16'(n), 16'h0004, "local period");
    wr(REG_START, 16'h0002);
    wr(REG_PERIOD, 16'h0007);
    spans(0, 2, n);
    check(16'(n), 16'h000C, "start offset");
    // Reload every fourth period
    wr(REG_CONTROL, 16'h0030);
    spans(1, 1, n);
    check(16'(n), 16'h0018, "reload rate");
    // Period fraction of a quarter clock
    wr(REG_PFRAC, 16'h4000);
    wr(REG_FRAC_CTRL, 16'h0001);
    spans(0, 8, n);
    check(16'(n), 16'h0032, "period fraction");
    wr(REG_FRAC_CTRL, 16'h0000);
    spans(0, 8, n);
    check(16'(n), 16'h0030, "fraction off");
    // Edges on gate A
    wr(REG_EDGE_BASE, 16'h0003);
    wr(REG_EDGE_BASE + 4'h1, 16'h0005);
    high(n);
    check(16'(n), 16'h0002, "pulse width");
    wr(REG_PFRAC, 16'h0000);
    wr(REG_EFRAC_BASE + 4'h1, 16'hB800);
    wr(REG_FRAC_CTRL, 16'h0001);
    high(n);
    check(16'(n), 16'h0002, "width with fraction");
    repeat (2) @(posedge clk_sys);
    #1 check({11'h0, fine_a}, 16'h0017, "edge fraction");
    // Fault with auto clearing and pin A released
    wr(REG_CONTROL, 16'h0500);
    @(posedge clk_sys);
    trip <= 1'b1;
    spans(0, 1, n);
    check(16'(n), 16'h0006, "runs in fault");
    check({15'h0, pins.a_oe}, 16'h0, "safe off");
    @(posedge clk_sys);
    trip <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check({15'h0, pins.a_oe}, 16'h0, "held to cycle");
    repeat (6) @(posedge clk_sys);
    #1 check({15'h0, pins.a_oe}, 16'h1, "auto clear");
    // Sticky period hit, write one to clear
    rdc(REG_STATUS, 16'h0002, "status after clear");
    wr(REG_STATUS, 16'h0002);
    rdc(REG_STATUS, 16'h0000, "period hit cleared");
    // Manual clear with pin B held high
    wr(REG_CONTROL, 16'h0800);
    @(posedge clk_sys);
    trip <= 1'b1;
    @(posedge clk_sys);
    trip <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 check({15'h0, gate_b}, 16'h1, "safe high held");
    rdc(REG_STATUS, 16'h0003, "fault latched");
    wr(REG_STATUS, 16'h0004);
    repeat (8) @(posedge clk_sys);
    #1 check({15'h0, gate_b}, 16'h0, "manual clear");
    rdc(REG_STATUS, 16'h0002, "clear request done");
    // Fine codes on output B edges
    wr(REG_EFRAC_BASE + 4'h2, 16'hF800);
    wr(REG_EFRAC_BASE + 4'h3, 16'hF800);
    wr(REG_EDGE_BASE + 4'h2, 16'h0003);
    wr(REG_EDGE_BASE + 4'h3, 16'h0005);
    repeat (8) @(posedge clk_sys);
    #1 check({11'h0, fine_b}, 16'h001F, "edge B fraction");
    test_done();
  end
endmodule : tb_top
